/* File: design/clp_cfg_map.svh */
/*
  Constants for the configuration low byte and block protection decoder.
  Assumes inclusion by the package and the top module.
*/
`ifndef CLP_CFG_MAP_SVH
`define CLP_CFG_MAP_SVH

`define CLP_CFG_LOW_OFFSET 24'h300000
`define CLP_PROT_OFFSET 24'h300008
`define CLP_STATUS_OFFSET 24'h300010
`define CLP_CFG_EXT_BIT 6
`define CLP_CFG_SECONDARY_OSCILLATOR_HI 4
`define CLP_CFG_SECONDARY_OSCILLATOR_LO 3
`define CLP_CFG_LFPWR_BIT 2
`define CLP_CFG_RSRC_BIT 0
`define CLP_CFG_IMPL_MASK 8'h5D
`define CLP_CFG_RESET 8'h5D
`define CLP_WDC_REGULATOR_SLEEP_CTL_BIT 7
`define CLP_WDC_RETENTION_SLEEP_CTL_BIT 4
`define CLP_NBLK 8
`define CLP_NBLK_SMALL 4
`define CLP_PROT_RESET 8'hFF
`define CLP_SECONDARY_OSCILLATOR_HIGH 2'h3
`define CLP_SECONDARY_OSCILLATOR_DIG 2'h2
`define CLP_SECONDARY_OSCILLATOR_LOW 2'h1
`define CLP_SECONDARY_OSCILLATOR_RSVD 2'h0

`endif

/* File: design/clp_pkg.sv */
/*
  Types for the configuration low byte decoder.
  Assumes clp_cfg_map.svh is on the include path.
*/
`include "clp_cfg_map.svh"

package clp_pkg;
  typedef enum logic [1:0] {
    CLP_SECONDARY_OSCILLATOR_RESERVED = 2'h0,
    CLP_SECONDARY_OSCILLATOR_LOW_PWR = 2'h1,
    CLP_SECONDARY_OSCILLATOR_DIGITAL = 2'h2,
    CLP_SECONDARY_OSCILLATOR_HIGH_PWR = 2'h3
  } clp_secondary_oscillator_mode_t;

  typedef struct packed {
    logic ext_instr_enable;
    logic indexed_addr_enable;
    logic secondary_oscillator_high_power;
    logic secondary_oscillator_low_power;
    logic sec_clock_digital_input;
    logic port_c_pins_gpio;
    logic secondary_oscillator_reserved;
    logic lf_osc_sleep_high_power;
    logic regulator_sleep_power;
    logic ulp_regulator_enable;
  } clp_cfg_out_t;

  typedef struct packed {
    logic [`CLP_NBLK-1:0] code_protect;
    logic [`CLP_NBLK-1:0] write_protect;
    logic [`CLP_NBLK-1:0] table_read_protect;
  } clp_prot_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } clp_bus_req_t;
endpackage : clp_pkg

/* File: design/clp_config_low.sv */
/*
  Configuration low byte decoder and per-block program memory protection.
  Assumes nonvolatile values are stable at reset and a single 100 MHz clock.
*/
// Added by the designer: the strobed register port.
// Functional notes
// - Extension bit set enables extended instructions and indexed addressing; clear means legacy.
// - Oscillator field: 11 high power, 10 digital input, 01 low power, 00 reserved.
// - Low-frequency oscillator stays high power in sleep when its bit is set.
// - Source bit picks regulator or retention control bit; clear also enables ULP regulator.
// - Unimplemented configuration bits 7, 5 and 1 read as zero.
// - Four protection blocks on small parts, eight on the largest; boot block first.
// - Each block has code, write and external table read protection.
`timescale 1ns/1ps
`default_nettype none
`include "clp_cfg_map.svh"

module clp_config_low
  import clp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic large_variant,
  input wire logic [7:0] nv_config_byte,
  input wire logic [`CLP_NBLK-1:0] nv_code_protect,
  input wire logic [`CLP_NBLK-1:0] nv_write_protect,
  input wire logic [`CLP_NBLK-1:0] nv_table_read_protect,
  input wire logic [7:0] watchdog_control_reg,
  input wire logic sleep_active,
  input wire logic [23:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output clp_cfg_out_t cfg_out,
  output clp_prot_t prot_out
);

  logic [7:0] cfg_byte;
  clp_prot_t prot;
  logic latched;
  logic [`CLP_NBLK-1:0] blk_valid;
  clp_secondary_oscillator_mode_t secondary_oscillator_mode;
  clp_cfg_out_t next_cfg;
  clp_prot_t next_prot;
  logic [7:0] next_rdata;

  // Capture on first cycle after reset release
  always_ff @(posedge clk) begin
    if (srst) begin
      latched <= 1'b0;
    end else begin
      latched <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_byte <= `CLP_CFG_RESET;
    end else if (!latched) begin
      cfg_byte <= nv_config_byte & `CLP_CFG_IMPL_MASK;
    end
  end

  // Blocks beyond the small count exist only on the large variant
  genvar gi;
  generate
    for (gi = 0; gi < `CLP_NBLK; gi++) begin : g_blk
      assign blk_valid[gi] = (gi < `CLP_NBLK_SMALL) || large_variant;
      always_ff @(posedge clk) begin
        if (srst) begin
          prot.code_protect[gi] <= 1'b1;
          prot.write_protect[gi] <= 1'b1;
          prot.table_read_protect[gi] <= 1'b1;
        end else if (!latched) begin
          prot.code_protect[gi] <= nv_code_protect[gi];
          prot.write_protect[gi] <= nv_write_protect[gi];
          prot.table_read_protect[gi] <= nv_table_read_protect[gi];
        end
      end
      assign next_prot.code_protect[gi] = prot.code_protect[gi] & blk_valid[gi];
      assign next_prot.write_protect[gi] = prot.write_protect[gi] & blk_valid[gi];
      assign next_prot.table_read_protect[gi] = prot.table_read_protect[gi] & blk_valid[gi];
    end
  endgenerate

  assign secondary_oscillator_mode = clp_secondary_oscillator_mode_t'(cfg_byte[`CLP_CFG_SECONDARY_OSCILLATOR_HI:`CLP_CFG_SECONDARY_OSCILLATOR_LO]);

  always_comb begin
    next_cfg = '0;
    next_cfg.ext_instr_enable = cfg_byte[`CLP_CFG_EXT_BIT];
    next_cfg.indexed_addr_enable = cfg_byte[`CLP_CFG_EXT_BIT];
    case (secondary_oscillator_mode)
      CLP_SECONDARY_OSCILLATOR_HIGH_PWR: next_cfg.secondary_oscillator_high_power = 1'b1;
      CLP_SECONDARY_OSCILLATOR_DIGITAL: begin
        next_cfg.sec_clock_digital_input = 1'b1;
        next_cfg.port_c_pins_gpio = 1'b1;
      end
      CLP_SECONDARY_OSCILLATOR_LOW_PWR: next_cfg.secondary_oscillator_low_power = 1'b1;
      default: next_cfg.secondary_oscillator_reserved = 1'b1;
    endcase
    next_cfg.lf_osc_sleep_high_power = cfg_byte[`CLP_CFG_LFPWR_BIT] & sleep_active;
    if (cfg_byte[`CLP_CFG_RSRC_BIT]) begin
      next_cfg.regulator_sleep_power = watchdog_control_reg[`CLP_WDC_REGULATOR_SLEEP_CTL_BIT];
      next_cfg.ulp_regulator_enable = 1'b0;
    end else begin
      next_cfg.regulator_sleep_power = watchdog_control_reg[`CLP_WDC_RETENTION_SLEEP_CTL_BIT];
      next_cfg.ulp_regulator_enable = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_out <= '0;
      prot_out <= '0;
    end else begin
      cfg_out <= next_cfg;
      prot_out <= next_prot;
    end
  end

  // Read-only register window; writes are ignored
  always_comb begin
    next_rdata = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        `CLP_CFG_LOW_OFFSET: next_rdata = cfg_byte & `CLP_CFG_IMPL_MASK;
        `CLP_PROT_OFFSET: next_rdata = next_prot.code_protect;
        `CLP_PROT_OFFSET + 24'h000001: next_rdata = next_prot.write_protect;
        `CLP_PROT_OFFSET + 24'h000002: next_rdata = next_prot.table_read_protect;
        `CLP_STATUS_OFFSET: next_rdata = {6'h00, large_variant, latched};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

endmodule : clp_config_low

`default_nettype wire

/* File: verif/clp_chk.sv */
/* Assertion checker for clp_config_low, bound to its ports.
   Assumes nonvolatile inputs are stable through reset. */
`timescale 1ns/1ps
`default_nettype none
module clp_chk
  import clp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic large_variant,
  input wire logic [7:0] nv_config_byte,
  input wire logic [7:0] nv_code_protect,
  input wire logic [7:0] nv_write_protect,
  input wire logic [7:0] nv_table_read_protect,
  input wire logic [7:0] watchdog_control_reg,
  input wire logic sleep_active,
  input wire logic [23:0] bus_addr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire clp_cfg_out_t cfg_out,
  input wire clp_prot_t prot_out
);
  logic [1:0] age;
  logic [31:0] cap;
  logic [7:0] cb;
  logic [1:0] sel;
  logic live;
  assign live = age == 2'h3;
  assign cb = cap[31:24];
  assign sel = cb[4:3];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Cycles since reset release
  always_ff @(posedge clk) begin
    age <= srst ? 2'h0 : age + {1'b0, ~live};
  end
  // Own copy of the values taken at release
  always_ff @(posedge clk) begin
    if (!srst && age == 2'h0) begin
      cap <= {nv_config_byte, nv_code_protect, nv_write_protect, nv_table_read_protect};
    end
  end
  a_ext_mode: assert property (live |-> cfg_out[9:8] == {2{cb[6]}})
    else $error("ext mode");
  a_osc_sel: assert property (live |-> cfg_out[7:3] == {sel == 2'h3, sel == 2'h1, {2{sel == 2'h2}}, sel == 2'h0})
    else $error("osc select");
  a_lf_sleep: assert property (live |-> cfg_out[2] == ($past(sleep_active) & cb[2]))
    else $error("lf sleep");
  a_reg_src: assert property (live |-> cfg_out[1:0] == {$past(watchdog_control_reg[cb[0] ? 7 : 4]), ~cb[0]})
    else $error("reg source");
  a_cfg_read: assert property (live && bus_rd && bus_addr == 24'h300000 |=> bus_rdata == (cb & 8'h5D))
    else $error("cfg read");
  a_small_part: assert property (live && !$past(large_variant) |-> {prot_out[23:20], prot_out[15:12], prot_out[7:4]} == 12'h000)
    else $error("small part");
  a_prot_map: assert property (live |-> prot_out == (cap[23:0] & {3{$past(large_variant) ? 8'hFF : 8'h0F}}))
    else $error("prot map");
  a_held_fixed: assert property (live |=> $stable(cfg_out[9:3]))
    else $error("held fixed");
  c_read: cover property (live && bus_rd);
  c_sleep: cover property (live && sleep_active && cb[2]);
  c_small: cover property (live && !large_variant);
endmodule : clp_chk
bind clp_config_low clp_chk i_chk (.clk, .srst, .large_variant, .nv_config_byte, .nv_code_protect,
  .nv_write_protect, .nv_table_read_protect, .watchdog_control_reg, .sleep_active, .bus_addr,
  .bus_rd, .bus_rdata, .cfg_out, .prot_out);
`default_nettype wire

/* File: verif/tb_top.sv */
/* Random and corner bench for clp_config_low.
   Assumes the design and clp_chk.sv compile first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import clp_pkg::*;
  logic clk = 1'b0, srst = 1'b1, lv = 1'b0, sl = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] nv = 8'h00, wdc = 8'h00, wd = 8'h00, c, rdat;
  logic [23:0] pr = 24'h000000, ad = 24'h000000, p;
  logic [15:0] r = 16'h681A;
  clp_cfg_out_t cfg;
  clp_prot_t prot;
  int num_errors = 0, n_checks = 0;
  always #5 clk = ~clk;
  clp_config_low i_dut (.clk, .srst, .large_variant(lv), .nv_config_byte(nv), .nv_code_protect(pr[23:16]),
    .nv_write_protect(pr[15:8]), .nv_table_read_protect(pr[7:0]), .watchdog_control_reg(wdc),
    .sleep_active(sl), .bus_addr(ad), .bus_wdata(wd), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdat),
    .cfg_out(cfg), .prot_out(prot));
  function logic [15:0] lfsr();
    r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    return r;
  endfunction : lfsr
  function clp_cfg_out_t exp_cfg(input logic [7:0] v, input logic [7:0] w, input logic s);
    return {v[6], v[6], v[4:3] == 2'h3, v[4:3] == 2'h1, v[4:3] == 2'h2, v[4:3] == 2'h2,
      v[4:3] == 2'h0, s & v[2], v[0] ? w[7] : w[4], ~v[0]};
  endfunction : exp_cfg
  task complete_run();
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task rd_chk(input logic [23:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    ad <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(32'(rdat), 32'(e), "rdata");
  endtask : rd_chk
  initial begin
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      c = 8'(lfsr());
      c[4:3] = i[1:0];
      p = {lfsr(), c};
      srst <= 1'b1;
      nv <= c;
      pr <= p;
      lv <= i[2];
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      nv <= ~c;
      pr <= ~p;
      {wdc, wd} <= lfsr();
      sl <= r[3];
      wr <= 1'b1;
      ad <= 24'h300000;
      @(posedge clk);
      wr <= 1'b0;
      #1 chk(32'(cfg), 32'(exp_cfg(c, wdc, sl)), "cfg");
      chk(32'(prot), 32'(p & {3{lv ? 8'hFF : 8'h0F}}), "prot");
      rd_chk(24'h300000, c & 8'h5D);
      rd_chk(24'h300004, 8'h00);
      rd_chk(24'h300008, p[23:16] & (lv ? 8'hFF : 8'h0F));
    end
    complete_run();
  end
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
